//--- drive_tune_pkg.sv
package drive_tune_pkg;

  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned START_WINDOW_S = 30;
  // Start window in clock cycles; 6e9 needs 33 bits
  localparam logic [32:0] START_WINDOW_CYC = 33'(START_WINDOW_S * CLK_HZ);

  // Nominal field current in internal units
  localparam logic [15:0] FIELD_NOM = 16'h1000;
  localparam logic [7:0] SPEED_TUNE_PCT = 8'h50;
  localparam logic [7:0] FLUX_TUNE_PCT = 8'h32;
  localparam logic [23:0] PCT_DIV = 24'h0064;
  localparam logic [1:0] SPEED_TUNE_PASSES = 2'h2;
  localparam logic [1:0] FLUX_TUNE_PASSES = 2'h1;

  // Bit positions of the synchronised pin vector
  localparam int PIN_LOCAL = 0;
  localparam int PIN_START = 1;
  localparam int PIN_STOP = 2;
  localparam int PIN_ON = 3;
  localparam int PIN_RUN = 4;
  localparam int PIN_COUNT = 5;

  typedef enum logic [2:0] {
    SVC_IDLE = 3'h0,
    SVC_ARM = 3'h1,
    SVC_FLD = 3'h2,
    SVC_FLD_MAN = 3'h3,
    SVC_SPEED = 3'h4,
    SVC_FLUX = 3'h5
  } service_type;

  typedef enum logic [1:0] {
    ALT_OFF = 2'h0,
    ALT_BELOW_LEV1 = 2'h1,
    ALT_ABOVE_LEV1 = 2'h2,
    ALT_DEV_ABOVE_LEV1 = 2'h3
  } alt_sel_type;

  typedef enum logic [1:0] {
    MSG_NONE = 2'h0,
    MSG_BUSY = 2'h1,
    MSG_FAILED = 2'h2
  } panel_msg_type;

  typedef struct packed {
    logic [15:0] kp;
    logic [15:0] ti;
    logic [15:0] accel;
    logic [15:0] decel;
  } speed_set_type;

  typedef struct packed {
    logic arm_wr;
    logic fld_wr;
    logic speed_wr;
    logic flux_wr;
    logic [4:0][15:0] words;
  } param_write_type;

endpackage

//--- alt_param_select.sv
`timescale 1ns/1ps
module alt_param_select
  import drive_tune_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire alt_sel_type alt_sel,
  input wire logic signed [15:0] speed_act,
  input wire logic signed [15:0] speed_ref,
  input wire logic [15:0] speed_lev1,
  input wire speed_set_type normal_set,
  input wire speed_set_type alt_set,
  output speed_set_type active_set,
  output logic alt_active,
  output logic integ_clear
);

  typedef struct packed {
    logic alt;
    logic clr;
    speed_set_type set;
  } alt_state_type;

  alt_state_type q, d;
  logic [15:0] abs_speed;
  logic signed [16:0] dev;
  logic cond;

  always_comb
  begin
    abs_speed = speed_act[15] ? 16'(-speed_act) : speed_act;
    dev = 17'(speed_act) - 17'(speed_ref);
    unique case (alt_sel)
      ALT_OFF: cond = 1'b0;
      ALT_BELOW_LEV1: cond = abs_speed < speed_lev1;
      ALT_ABOVE_LEV1: cond = abs_speed >= speed_lev1;
      ALT_DEV_ABOVE_LEV1: cond = dev > $signed({1'b0, speed_lev1});
    endcase
    d.alt = cond;
    d.set = cond ? alt_set : normal_set;
    // Zero integral time in the alternate set dumps the integrator
    d.clr = cond && (alt_set.ti == 16'h0000);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign active_set = q.set;
  assign alt_active = q.alt;
  assign integ_clear = q.clr;

  property p_below_lev1;
    @(posedge clk) disable iff (rst)
    (alt_sel == ALT_BELOW_LEV1 && abs_speed < speed_lev1) |=> alt_active && active_set == $past(alt_set);
  endproperty
  a_below_lev1: assert property (p_below_lev1) else $error("alt set not taken below level one");

  property p_set_follows;
    @(posedge clk) disable iff (rst)
    alt_active |-> active_set.kp == $past(alt_set.kp) && active_set.decel == $past(alt_set.decel);
  endproperty
  a_set_follows: assert property (p_set_follows) else $error("active set not alternate");

  property p_integ_clear;
    @(posedge clk) disable iff (rst)
    integ_clear |-> alt_active && $past(alt_set.ti) == 16'h0000;
  endproperty
  a_integ_clear: assert property (p_integ_clear) else $error("integral clear without zero time");

endmodule // alt_param_select

//--- square_wave_gen.sv
`timescale 1ns/1ps
module square_wave_gen
  import drive_tune_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic signed [15:0] ref1,
  input wire logic signed [15:0] ref2,
  input wire logic [31:0] period_cyc,
  output logic signed [15:0] wave_out,
  output logic [15:0] field_ref
);

  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
    logic signed [15:0] wave;
    logic [15:0] fref;
  } sqw_state_type;

  sqw_state_type q, d;
  logic [31:0] half;
  logic signed [15:0] lvl;

  always_comb
  begin
    // Half period per level; a period below two still toggles
    half = (period_cyc < 32'h0000_0002) ? 32'h0000_0001 : (period_cyc >> 1);
    d = q;
    if (!enable)
    begin
      d.cnt = '0;
      d.phase = 1'b0;
    end
    else if (q.cnt >= half - 32'h0000_0001)
    begin
      d.cnt = '0;
      d.phase = !q.phase;
    end
    else
      d.cnt = q.cnt + 32'h0000_0001;
    lvl = d.phase ? ref2 : ref1;
    d.wave = lvl;
    if (!enable || lvl[15])
      d.fref = 16'h0000;
    else if (lvl > $signed({1'b0, FIELD_NOM[14:0]}) || lvl[15:12] != 4'h0 && lvl != 16'sh1000)
      d.fref = FIELD_NOM;
    else
      d.fref = 16'(lvl);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign wave_out = q.wave;
  assign field_ref = q.fref;

  property p_clamp;
    @(posedge clk) disable iff (rst)
    field_ref <= FIELD_NOM;
  endproperty
  a_clamp: assert property (p_clamp) else $error("field reference above nominal");

  property p_toggle;
    @(posedge clk) disable iff (rst)
    (enable && $past(enable) && q.cnt == 32'h0000_0000 && $past(q.cnt) != 32'h0000_0000) |-> q.phase != $past(q.phase);
  endproperty
  a_toggle: assert property (p_toggle) else $error("square wave missed its edge");

endmodule // square_wave_gen

//--- drive_service_tuning_sequencer.sv
`timescale 1ns/1ps
// Function
// - Alternate set replaces gains and ramps
// - Alternate set chosen from speed or deviation
// - Below level one selects alternate set
// - Zero alternate integral time clears integrator
// - Service codes accepted; local mode, then confirm
// - Start within thirty seconds begins tuning
// - Success shows no-fault panel message
// - Failure raises alarm, stores diagnosis code
// - Second local toggle returns terminal control
// - Armature tune writes five current parameters
// - Field tune writes field and EMF gains
// - Speed tune writes speed gain, integral time
// - Speed tune runs twice to eighty percent
// - Square wave alternates two refs per period
// - Manual field starts on selection and drive on
// - Manual field: no armature, clamped field reference
// - Manual field aborts on zero or switch-off
// - Flux adaptation writes three flux currents
// - Flux adaptation runs to half base speed
module drive_service_tuning_sequencer
  import drive_tune_pkg::*;
#(
  parameter logic [32:0] START_WINDOW_CYCLES = START_WINDOW_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic local_mode_toggle,
  input wire logic panel_start,
  input wire logic panel_stop,
  input wire logic term_on,
  input wire logic term_run,
  input wire logic svc_wr,
  input wire logic [2:0] svc_code,
  input wire logic svc_confirm,
  input wire logic tune_pass,
  input wire logic tune_done,
  input wire logic tune_ok,
  input wire logic [7:0] tune_diag,
  input wire logic [4:0][15:0] tune_words,
  input wire logic [15:0] base_speed,
  input wire alt_sel_type alt_sel,
  input wire logic signed [15:0] speed_act,
  input wire logic signed [15:0] speed_ref,
  input wire logic [15:0] speed_lev1,
  input wire speed_set_type normal_set,
  input wire speed_set_type alt_set,
  input wire logic signed [15:0] commis_ref1,
  input wire logic signed [15:0] commis_ref2,
  input wire logic [31:0] sqw_period_cyc,
  output speed_set_type active_set,
  output logic alt_active,
  output logic speed_integ_clear,
  output logic local_mode,
  output logic drive_run,
  output service_type service_sel,
  output logic tune_req,
  output service_type tune_kind,
  output logic [15:0] speed_target,
  output panel_msg_type panel_msg,
  output logic tune_failed_alarm,
  output logic [7:0] diag_code,
  output param_write_type param_wr,
  output logic field_only,
  output logic signed [15:0] sqw_out,
  output logic [15:0] field_ref
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_TUNING = 2'h2,
    ST_MAN_FIELD = 2'h3
  } seq_st_type;

  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    seq_st_type st;
    service_type svc;
    service_type kind;
    logic local_q;
    logic run;
    logic alarm;
    logic req;
    logic fonly;
    logic [1:0] passes;
    logic [32:0] win;
    logic [7:0] diag;
    panel_msg_type msg;
    logic [15:0] target;
    param_write_type wr;
  } seq_state_type;

  seq_state_type q, d;
  logic [PIN_COUNT-1:0] pins;
  logic loc_edge, start_edge, stop_edge, drive_on;
  logic [7:0] pct;
  logic [23:0] prod;

  assign pins = {term_run, term_on, panel_stop, panel_start, local_mode_toggle};

  always_comb
  begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    loc_edge = q.s2[PIN_LOCAL] && !q.s3[PIN_LOCAL];
    start_edge = q.s2[PIN_START] && !q.s3[PIN_START];
    stop_edge = q.s2[PIN_STOP] && !q.s3[PIN_STOP];
    d.req = 1'b0;
    d.wr.arm_wr = 1'b0;
    d.wr.fld_wr = 1'b0;
    d.wr.speed_wr = 1'b0;
    d.wr.flux_wr = 1'b0;

    // Each press flips authority between panel and terminals
    if (loc_edge)
      d.local_q = !q.local_q;

    // Panel on/off only while local; terminals need on and run
    if (!d.local_q)
      d.run = 1'b0;
    else if (stop_edge)
      d.run = 1'b0;
    else if (start_edge)
      d.run = 1'b1;
    drive_on = q.local_q ? q.run : (q.s2[PIN_ON] && q.s2[PIN_RUN]);

    // Selector writes blocked only while tuning; unknown codes ignored
    if (svc_wr && svc_code <= 3'(SVC_FLUX) && q.st != ST_TUNING)
      d.svc = service_type'(svc_code);

    unique case (q.st)
      ST_IDLE:
      begin
        if (svc_confirm && q.local_q && q.svc != SVC_IDLE && q.svc != SVC_FLD_MAN)
        begin
          d.st = ST_ARMED;
          d.win = START_WINDOW_CYCLES - 33'h0_0000_0001;
        end
        else if (q.svc == SVC_FLD_MAN && drive_on)
        begin
          d.st = ST_MAN_FIELD;
          d.fonly = 1'b1;
        end
      end
      ST_ARMED:
      begin
        if (start_edge && q.local_q)
        begin
          d.st = ST_TUNING;
          d.req = 1'b1;
          d.kind = q.svc;
          d.passes = 2'h0;
          d.msg = MSG_BUSY;
          d.alarm = 1'b0;
        end
        else if (q.win == 33'h0_0000_0000 || !q.local_q || d.svc == SVC_IDLE)
        begin
          d.st = ST_IDLE;
          d.svc = SVC_IDLE;
        end
        else
          d.win = q.win - 33'h0_0000_0001;
      end
      ST_TUNING:
      begin
        if (tune_pass && q.passes != 2'h3)
          d.passes = q.passes + 2'h1;
        if (tune_done)
        begin
          d.st = ST_IDLE;
          d.svc = SVC_IDLE;
          if (tune_ok)
          begin
            d.msg = MSG_NONE;
            d.wr.words = tune_words;
            d.wr.arm_wr = q.kind == SVC_ARM;
            d.wr.fld_wr = q.kind == SVC_FLD;
            d.wr.speed_wr = q.kind == SVC_SPEED;
            d.wr.flux_wr = q.kind == SVC_FLUX;
          end
          else
          begin
            // Alarm stays until the next tune starts
            d.alarm = 1'b1;
            d.diag = tune_diag;
            d.msg = MSG_FAILED;
          end
        end
      end
      ST_MAN_FIELD:
      begin
        if (!drive_on || d.svc == SVC_IDLE)
        begin
          d.st = ST_IDLE;
          d.svc = SVC_IDLE;
          d.fonly = 1'b0;
        end
      end
    endcase

    // Speed run sets its target twice, flux adaptation once
    pct = 8'h00;
    if (d.st == ST_TUNING && d.kind == SVC_SPEED && d.passes < SPEED_TUNE_PASSES)
      pct = SPEED_TUNE_PCT;
    else if (d.st == ST_TUNING && d.kind == SVC_FLUX && d.passes < FLUX_TUNE_PASSES)
      pct = FLUX_TUNE_PCT;
    prod = 24'(base_speed) * 24'(pct);
    d.target = 16'(prod / PCT_DIV);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  alt_param_select u_alt (
    .clk(clk),
    .rst(rst),
    .alt_sel(alt_sel),
    .speed_act(speed_act),
    .speed_ref(speed_ref),
    .speed_lev1(speed_lev1),
    .normal_set(normal_set),
    .alt_set(alt_set),
    .active_set(active_set),
    .alt_active(alt_active),
    .integ_clear(speed_integ_clear)
  );

  square_wave_gen u_sqw (
    .clk(clk),
    .rst(rst),
    .enable(q.fonly),
    .ref1(commis_ref1),
    .ref2(commis_ref2),
    .period_cyc(sqw_period_cyc),
    .wave_out(sqw_out),
    .field_ref(field_ref)
  );

  assign local_mode = q.local_q;
  assign drive_run = q.run;
  assign service_sel = q.svc;
  assign tune_req = q.req;
  assign tune_kind = q.kind;
  assign speed_target = q.target;
  assign panel_msg = q.msg;
  assign tune_failed_alarm = q.alarm;
  assign diag_code = q.diag;
  assign param_wr = q.wr;
  assign field_only = q.fonly;

  property p_window_expiry;
    @(posedge clk) disable iff (rst)
    (q.st == ST_ARMED && q.win == 33'h0_0000_0000 && !start_edge) |=> q.st == ST_IDLE && service_sel == SVC_IDLE;
  endproperty
  a_window_expiry: assert property (p_window_expiry) else $error("armed request outlived window");

  property p_start;
    @(posedge clk) disable iff (rst)
    (q.st == ST_ARMED && start_edge && local_mode) |=> tune_req && tune_kind == $past(q.svc) ##1 !tune_req;
  endproperty
  a_start: assert property (p_start) else $error("start did not launch tune");

  property p_success;
    @(posedge clk) disable iff (rst)
    (q.st == ST_TUNING && tune_done && tune_ok) |=> panel_msg == MSG_NONE && !tune_failed_alarm;
  endproperty
  a_success: assert property (p_success) else $error("success not reported");

  property p_failure;
    @(posedge clk) disable iff (rst)
    (q.st == ST_TUNING && tune_done && !tune_ok) |=> tune_failed_alarm && diag_code == $past(tune_diag);
  endproperty
  a_failure: assert property (p_failure) else $error("failure not flagged");

  property p_arm_write;
    @(posedge clk) disable iff (rst)
    (q.st == ST_TUNING && tune_done && tune_ok && q.kind == SVC_ARM) |=> param_wr.arm_wr && !param_wr.speed_wr ##1 !param_wr.arm_wr;
  endproperty
  a_arm_write: assert property (p_arm_write) else $error("armature results not written");

  property p_local_off;
    @(posedge clk) disable iff (rst)
    (loc_edge && local_mode) |=> !local_mode && !drive_run;
  endproperty
  a_local_off: assert property (p_local_off) else $error("second toggle kept local mode");

  property p_man_abort;
    @(posedge clk) disable iff (rst)
    (q.st == ST_MAN_FIELD && !drive_on) |=> service_sel == SVC_IDLE && !field_only;
  endproperty
  a_man_abort: assert property (p_man_abort) else $error("switch-off did not abort field tune");

  property p_speed_target;
    @(posedge clk) disable iff (rst)
    (q.st == ST_TUNING && q.kind == SVC_SPEED && q.passes == 2'h0 && !tune_done && !tune_pass)
      |=> speed_target == 16'((24'($past(base_speed)) * 24'(SPEED_TUNE_PCT)) / PCT_DIV);
  endproperty
  a_speed_target: assert property (p_speed_target) else $error("speed tune target wrong");

  property p_man_start;
    @(posedge clk) disable iff (rst)
    (q.st == ST_IDLE && q.svc == SVC_FLD_MAN && drive_on && !svc_confirm) |=> field_only
      ##1 field_ref == (sqw_out[15] ? 16'h0000 : (sqw_out > $signed(FIELD_NOM) ? FIELD_NOM : 16'(sqw_out)));
  endproperty
  a_man_start: assert property (p_man_start) else $error("manual field tune did not start");

endmodule // drive_service_tuning_sequencer

//--- panel_model.sv
`timescale 1ns/1ps
module panel_model
(
  input wire logic clk,
  output logic local_mode_toggle,
  output logic panel_start,
  output logic panel_stop,
  output logic term_on,
  output logic term_run
);
  logic [2:0] btn;

  assign local_mode_toggle = btn[0];
  assign panel_start = btn[1];
  assign panel_stop = btn[2];

  initial
  begin
    btn = 3'h0;
    term_on = 1'b0;
    term_run = 1'b0;
  end

  // Held and released 4 cycles each, beyond the 3-cycle sync spacing
  task automatic press(input int b);
    @(negedge clk);
    btn[b] = 1'b1;
    repeat (4) @(negedge clk);
    btn[b] = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic drive_on(input logic on, input logic run);
    @(negedge clk);
    term_on = on;
    term_run = run;
  endtask
endmodule // panel_model

//--- drive_service_tuning_sequencer_test.sv
`timescale 1ns/1ps
module drive_service_tuning_sequencer_test
  import drive_tune_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic local_mode_toggle, panel_start, panel_stop, term_on, term_run;
  logic svc_wr = 1'b0, svc_confirm = 1'b0, tune_pass = 1'b0, tune_done = 1'b0, tune_ok = 1'b0;
  logic [2:0] svc_code = 3'h0;
  logic [7:0] tune_diag = 8'h00;
  logic [4:0][15:0] tune_words = '0;
  logic [15:0] base_speed = 16'h4E20;
  logic [15:0] speed_lev1 = 16'h0100;
  alt_sel_type alt_sel = ALT_OFF;
  logic signed [15:0] speed_act = 16'h0000, speed_ref = 16'h0100;
  logic signed [15:0] commis_ref1 = 16'hFF9C, commis_ref2 = 16'h1388;
  speed_set_type normal_set = 64'h0010_0020_0030_0040;
  speed_set_type alt_set = 64'h0011_0000_0033_0044;
  logic [31:0] sqw_period_cyc = 32'h0000_0008;
  speed_set_type active_set;
  logic alt_active, speed_integ_clear, local_mode, drive_run, tune_req, tune_failed_alarm, field_only;
  service_type service_sel, tune_kind, seen_kind;
  logic [15:0] speed_target, field_ref;
  panel_msg_type panel_msg;
  logic [7:0] diag_code;
  param_write_type param_wr;
  logic signed [15:0] sqw_out;
  logic [3:0] wv;
  int err_total = 0;
  int tests_run = 0;
  int req_cnt = 0;
  int wr_cnt[4] = '{0, 0, 0, 0};
  alt_sel_type a_sel[5] = '{ALT_BELOW_LEV1, ALT_BELOW_LEV1, ALT_ABOVE_LEV1, ALT_ABOVE_LEV1, ALT_DEV_ABOVE_LEV1};
  logic [15:0] a_act[5] = '{16'h0080, 16'h0200, 16'h0200, 16'h0080, 16'h0300};
  logic a_exp[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  always #2.5 clk = ~clk;

  panel_model panel (.clk, .local_mode_toggle, .panel_start, .panel_stop, .term_on, .term_run);

  // Short start window keeps the expiry test brief
  drive_service_tuning_sequencer #(.START_WINDOW_CYCLES(33'h0_0000_0032)) dut (
    .clk, .rst, .local_mode_toggle, .panel_start, .panel_stop, .term_on, .term_run,
    .svc_wr, .svc_code, .svc_confirm, .tune_pass, .tune_done, .tune_ok, .tune_diag,
    .tune_words, .base_speed, .alt_sel, .speed_act, .speed_ref, .speed_lev1, .normal_set,
    .alt_set, .commis_ref1, .commis_ref2, .sqw_period_cyc, .active_set, .alt_active,
    .speed_integ_clear, .local_mode, .drive_run, .service_sel, .tune_req, .tune_kind,
    .speed_target, .panel_msg, .tune_failed_alarm, .diag_code, .param_wr, .field_only,
    .sqw_out, .field_ref);

  assign wv = {param_wr.arm_wr, param_wr.fld_wr, param_wr.speed_wr, param_wr.flux_wr};

  // Pulses last one cycle, so they are counted here
  always @(posedge clk)
  begin
    if (tune_req === 1'b1)
    begin
      req_cnt++;
      seen_kind = tune_kind;
    end
    for (int i = 0; i < 4; i++)
      if (wv[3 - i] === 1'b1) wr_cnt[i]++;
  end

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic select(input logic [2:0] code, input logic conf);
    @(negedge clk);
    svc_code = code;
    svc_wr = 1'b1;
    @(negedge clk);
    svc_wr = 1'b0;
    if (conf)
    begin
      @(negedge clk);
      svc_confirm = 1'b1;
      @(negedge clk);
      svc_confirm = 1'b0;
    end
  endtask

  task automatic wait_req(input int n);
    int k;
    for (k = 0; k < 20 && req_cnt != n; k++)
      @(negedge clk);
    if (req_cnt != n)
    begin
      check(req_cnt, n);
      wrap_up();
    end
  endtask

  task automatic run_tune(input logic [2:0] code, input int passes, input logic ok, input int wi,
                          input logic [15:0] tgt);
    int w;
    int r0;
    // Count taken first; the launch pulse lands inside the press
    w = wr_cnt[wi];
    r0 = req_cnt;
    select(code, 1'b1);
    panel.press(1);
    wait_req(r0 + 1);
    check(seen_kind, code);
    check(panel_msg, MSG_BUSY);
    check(speed_target, tgt);
    for (int p = 1; p <= passes; p++)
    begin
      @(negedge clk);
      tune_pass = 1'b1;
      @(negedge clk);
      tune_pass = 1'b0;
      @(negedge clk);
      check(speed_target, (p == passes) ? 16'h0000 : tgt);
    end
    @(negedge clk);
    tune_words = {64'hA004_A003_A002_A001, 13'h0000, code};
    tune_ok = ok;
    tune_diag = 8'h5A;
    tune_done = 1'b1;
    @(negedge clk);
    tune_done = 1'b0;
    @(negedge clk);
    check(wr_cnt[wi] - w, ok ? 1 : 0);
    check(tune_failed_alarm, !ok);
    check(panel_msg, ok ? MSG_NONE : MSG_FAILED);
    if (ok)
      check(param_wr.words, tune_words);
    else
      check(diag_code, 8'h5A);
    $display("test tune %0d done", code);
  endtask

  initial
  begin
    int r;
    int lo;
    int hi;
    int tq[$];
    logic signed [15:0] prev;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(service_sel, SVC_IDLE);
    check(local_mode, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk);
      alt_sel = a_sel[i];
      speed_act = a_act[i];
      repeat (3) @(negedge clk);
      check(alt_active, a_exp[i]);
      check(active_set, a_exp[i] ? alt_set : normal_set);
      check(speed_integ_clear, a_exp[i]);
    end
    $display("test alternate set done");
    panel.press(0);
    check(local_mode, 1'b1);
    run_tune(SVC_SPEED, 2, 1'b1, 2, 16'h3E80);
    run_tune(SVC_ARM, 0, 1'b1, 0, 16'h0000);
    run_tune(SVC_FLD, 0, 1'b1, 1, 16'h0000);
    run_tune(SVC_FLUX, 1, 1'b1, 3, 16'h2710);
    run_tune(SVC_ARM, 0, 1'b0, 0, 16'h0000);
    // Armed request must lapse once the start window runs out
    select(SVC_SPEED, 1'b1);
    repeat (40) @(negedge clk);
    check(service_sel, SVC_SPEED);
    repeat (20) @(negedge clk);
    check(service_sel, SVC_IDLE);
    r = req_cnt;
    panel.press(1);
    check(req_cnt, r);
    check(drive_run, 1'b1);
    panel.press(2);
    check(drive_run, 1'b0);
    panel.press(1);
    panel.press(0);
    check(local_mode, 1'b0);
    check(drive_run, 1'b0);
    $display("test window and local done");
    select(SVC_FLD_MAN, 1'b0);
    panel.drive_on(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    check(field_only, 1'b1);
    lo = 0;
    hi = 0;
    prev = sqw_out;
    for (int k = 0; k < 24; k++)
    begin
      @(negedge clk);
      if (sqw_out !== prev) tq.push_back(k);
      prev = sqw_out;
      if (field_ref === 16'h0000) lo++;
      if (field_ref === 16'h1000) hi++;
    end
    check(tq[2] - tq[1], 4);
    check({lo > 0, hi > 0}, 2'b11);
    // Writing zero aborts; rewriting the code restarts while still on
    select(SVC_IDLE, 1'b0);
    check(field_only, 1'b0);
    select(SVC_FLD_MAN, 1'b0);
    repeat (2) @(negedge clk);
    check(field_only, 1'b1);
    panel.drive_on(1'b0, 1'b0);
    repeat (3) @(negedge clk);
    check(field_only, 1'b0);
    check(service_sel, SVC_IDLE);
    $display("test manual field done");
    wrap_up();
  end
endmodule // drive_service_tuning_sequencer_test
